// *** verilog/mct_regs.svh ***
// Purpose: Offsets, reset values and counts of the memory timing block
// Assumes: 32-bit APB, word aligned registers
// Notes: Included by the top module, the checker and the bench
`ifndef MCT_REGS_SVH
`define MCT_REGS_SVH
`define MCT_GMR_OFF 12'h000
`define MCT_OPT_OFF 12'h004
`define MCT_CYC_OFF 12'h008
`define MCT_STAT_OFF 12'h00C
`define MCT_REF_DIV 5'd16
`define MCT_REFRESH_PERIOD_COUNT_RST 8'h17
`define MCT_OPT_RST 8'h00
`endif

// *** verilog/mct_pkg.sv ***
// Purpose: Types of the memory timing block
// Assumes: Nothing beyond the header
// Notes: Option register layout is packed high to low, bit 7 first
package mct_pkg;
  typedef enum logic [3:0] {
    MCT_IDLE = 4'b0001,
    MCT_RUN = 4'b0010,
    MCT_XTRA = 4'b0100,
    MCT_DONE = 4'b1000
  } mct_state_t;

  typedef struct packed {
    logic burst_strobe_extra_setup;
    logic early_select_negate;
    logic sync_timing;
    logic burst_ack_select;
    logic page_mode_enable;
    logic write_delay_select;
    logic parity_enable;
    logic is_dram;
  } mct_opt_t;

  typedef struct packed {
    logic [7:0] refresh_period_count;
    logic [7:0] ref_cnt;
    logic [3:0] div_cnt;
    logic refresh_req;
    logic [2:0] page_size_select;
    mct_opt_t opt;
    logic [3:0] cycle_wait_count;
    mct_state_t st;
    logic [4:0] cyc_cnt;
    logic [4:0] cyc_len;
    logic is_write;
    logic cas;
    logic cs;
    logic burst_inhibit_output;
    logic parity_active;
    logic [16:0] page_tag;
    logic page_valid;
    logic page_hit;
    logic cycle_done;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } mct_state_s_t;
endpackage : mct_pkg

// *** verilog/mct_top.sv ***
// Purpose: Memory controller timing: refresh, page compare, cycle length
// Assumes: Single clock, synchronous reset, APB register access
// Notes: One access port drives one memory cycle at a time
//
// How it works
// - A refresh request is made every count plus one ticks of clk/16.
// - Page size code 000..111 picks the upper address lines compared.
// - Write delay set adds one clock to CAS on page-hit writes.
// - Write delay clear makes DRAM reads and writes equal length.
// - Burst cycles last wait count plus two, or plus three with setup.
// - Parity is off for cycles ended by external acknowledges.
// - Early select negation works regardless of the sync timing bit.
// - Burst ack select zero asserts burst inhibit on every access.
// - Option bits 3 and 2 reset from the configuration pin.
`timescale 1ns/1ps
`include "mct_regs.svh"
module mct_top
  import mct_pkg::*;
#(
  parameter int ADDR_W = 26
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [1:0] cfg_pin,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic acc_req,
  input wire logic acc_write,
  input wire logic acc_burst,
  input wire logic port32,
  input wire logic [ADDR_W-1:0] acc_addr,
  input wire logic size_ack_input,
  input wire logic transfer_ack_input,
  output logic acc_done,
  output logic cas_out,
  output logic cs_out,
  output logic burst_inhibit_output,
  output logic page_hit,
  output logic parity_active,
  output logic refresh_req
);
  // Page compare reaches A25 at most, so only a 26-bit bus is served
  if (ADDR_W != 26) begin : g_bad_addr_w
    $error("ADDR_W must be 26");
  end

  mct_state_s_t s_reg, s_next;
  logic cfg_load_reg;

  // Page compare low bit; A25 is always the top compared line
  function automatic logic [3:0] page_low(input logic [2:0] pgs,
                                          input logic p32);
    logic [3:0] b;
    b = 4'd10 + {2'b00, pgs[2:1]} + {3'b000, pgs[0] | (pgs == 3'b111)};
    if (pgs == 3'b000) b = 4'd10;
    if (!p32) b = b - 4'd1;
    page_low = b;
  endfunction : page_low

  // Up to 17 lines compared at the smallest page on a 16-bit port
  function automatic logic [16:0] page_tag_of(input logic [25:0] a,
                                              input logic [3:0] lo);
    logic [25:0] sh;
    sh = a >> lo;
    page_tag_of = sh[16:0];
  endfunction : page_tag_of

  // Strap caught by a clocked process at release, never by the reset itself
  always_ff @(posedge core_clk) begin
    cfg_load_reg <= sys_rst;
  end

  always_comb begin
    logic wr, hit_now;
    logic [3:0] lo;
    logic [16:0] tag;
    s_next = s_reg;
    wr = psel && penable && pwrite;
    lo = page_low(s_reg.page_size_select, port32);
    tag = page_tag_of(acc_addr, lo);
    hit_now = s_reg.page_valid && (tag == s_reg.page_tag);
    // Ready only in the access phase, one wait state after setup
    s_next.pready = psel && penable && !s_reg.pready;
    s_next.pslverr = 1'b0;
    s_next.prdata = 32'h0000_0000;
    s_next.cycle_done = 1'b0;
    if (cfg_load_reg) begin
      s_next.opt.page_mode_enable = cfg_pin[1];
      s_next.opt.write_delay_select = cfg_pin[0];
    end
    // Refresh tick at clk/16
    s_next.refresh_req = 1'b0;
    s_next.div_cnt = s_reg.div_cnt + 4'd1;
    if (s_reg.div_cnt == 4'hf) begin
      if (s_reg.ref_cnt == 8'h00) begin
        s_next.refresh_req = 1'b1;
        s_next.ref_cnt = s_reg.refresh_period_count;
      end else begin
        s_next.ref_cnt = s_reg.ref_cnt - 8'h01;
      end
    end
    if (psel && penable && !s_reg.pready) begin
      case (paddr)
        `MCT_GMR_OFF: begin
          if (wr) begin
            s_next.refresh_period_count = pwdata[7:0];
            s_next.page_size_select = pwdata[10:8];
            s_next.page_valid = 1'b0;
          end
          s_next.prdata = {21'h00_0000, s_reg.page_size_select,
                           s_reg.refresh_period_count};
        end
        `MCT_OPT_OFF: begin
          if (wr) s_next.opt = pwdata[7:0];
          s_next.prdata = {24'h00_0000, s_reg.opt};
        end
        `MCT_CYC_OFF: begin
          if (wr) s_next.cycle_wait_count = pwdata[3:0];
          s_next.prdata = {28'h000_0000, s_reg.cycle_wait_count};
        end
        `MCT_STAT_OFF: begin
          s_next.prdata = {19'h0_0000, s_reg.cyc_len, s_reg.st,
                           s_reg.page_valid, s_reg.page_hit,
                           s_reg.burst_inhibit_output, s_reg.cas};
        end
        default: begin
          s_next.pslverr = 1'b1;
        end
      endcase
    end
    case (s_reg.st)
      MCT_IDLE: begin
        if (acc_req) begin
          s_next.is_write = acc_write;
          s_next.cs = 1'b1;
          s_next.cyc_cnt = 5'd1;
          s_next.page_hit = s_reg.opt.is_dram && s_reg.opt.page_mode_enable
                            && hit_now;
          s_next.page_tag = tag;
          s_next.page_valid = s_reg.opt.is_dram;
          s_next.burst_inhibit_output = !s_reg.opt.burst_ack_select;
          s_next.parity_active = s_reg.opt.parity_enable;
          if (acc_burst)
            s_next.cyc_len = {1'b0, s_reg.cycle_wait_count} + 5'd2 +
                             {4'd0, s_reg.opt.burst_strobe_extra_setup};
          else
            s_next.cyc_len = {1'b0, s_reg.cycle_wait_count} + 5'd2;
          // Delayed CAS on page-hit writes holds it off for one clock
          s_next.cas = !(s_reg.opt.write_delay_select && acc_write &&
                         s_next.page_hit);
          s_next.st = MCT_RUN;
        end
      end
      MCT_RUN: begin
        s_next.cyc_cnt = s_reg.cyc_cnt + 5'd1;
        s_next.cas = 1'b1;
        if (size_ack_input || transfer_ack_input)
          s_next.parity_active = 1'b0;
        // Early negation ignores sync timing on purpose
        if (acc_burst && s_reg.opt.early_select_negate &&
            s_reg.cyc_cnt + 5'd1 == s_reg.cyc_len)
          s_next.cs = 1'b0;
        if (s_reg.cyc_cnt + 5'd1 >= s_reg.cyc_len ||
            size_ack_input || transfer_ack_input) begin
          if (s_reg.opt.write_delay_select && s_reg.is_write &&
              s_reg.page_hit)
            s_next.st = MCT_XTRA;
          else
            s_next.st = MCT_DONE;
        end
      end
      MCT_XTRA: begin
        s_next.st = MCT_DONE;
      end
      MCT_DONE: begin
        s_next.cas = 1'b0;
        s_next.cs = 1'b0;
        s_next.burst_inhibit_output = 1'b0;
        s_next.parity_active = 1'b0;
        s_next.cycle_done = 1'b1;
        s_next.st = MCT_IDLE;
      end
      default: begin
        s_next.st = MCT_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_reg <= '0;
      s_reg.refresh_period_count <= `MCT_REFRESH_PERIOD_COUNT_RST;
      s_reg.ref_cnt <= `MCT_REFRESH_PERIOD_COUNT_RST;
      s_reg.opt <= `MCT_OPT_RST;
      s_reg.st <= MCT_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pready = s_reg.pready;
  assign prdata = s_reg.prdata;
  assign pslverr = s_reg.pslverr;
  assign acc_done = s_reg.cycle_done;
  assign cas_out = s_reg.cas;
  assign cs_out = s_reg.cs;
  assign burst_inhibit_output = s_reg.burst_inhibit_output;
  assign page_hit = s_reg.page_hit;
  assign parity_active = s_reg.parity_active;
  assign refresh_req = s_reg.refresh_req;
endmodule : mct_top

// *** verification/mct_top_chk.sv ***
// Purpose: Port assertions for mct_top
// Assumes: One clock, sync reset
// Notes: Bound from the bench top file
`timescale 1ns/1ps
`include "mct_regs.svh"
module mct_top_chk (
  input wire logic core_clk, sys_rst, psel, penable, pwrite, pready,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic pslverr, acc_done, cs_out, burst_inhibit_output,
  input wire logic parity_active, refresh_req, size_ack_input,
  input wire logic transfer_ack_input
);
  logic bas_reg;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Burst ack select is only visible through APB writes
  always_ff @(posedge core_clk)
    if (sys_rst) bas_reg <= 1'b0;
    else if (psel && penable && pready && pwrite && paddr == `MCT_OPT_OFF)
      bas_reg <= pwdata[4];
  AST_REF_GAP: assert property (refresh_req |=> !refresh_req [*8])
    else $error("refresh pulses too close");
  AST_INHIBIT: assert property (cs_out |-> burst_inhibit_output == !bas_reg)
    else $error("burst inhibit wrong");
  AST_PAR_ACK: assert property (size_ack_input || transfer_ack_input
    |=> !parity_active)
    else $error("parity on acked cycle");
  AST_RDY_ONE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_RDY_WAIT: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready not one wait state");
  AST_SLVERR: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("slave error without ready or zero data");
  AST_DONE_ONE: assert property (acc_done |=> !acc_done)
    else $error("done longer than one cycle");
  AST_DONE_CS: assert property (acc_done |-> $past(cs_out, 2) ||
    $past(cs_out, 3))
    else $error("done without a cycle");
endmodule : mct_top_chk

// *** verification/mct_mem_model.sv ***
// Purpose: Memory device that may end a cycle by acknowledge
// Assumes: Delay counted in clocks of chip select
// Notes: Zero delay leaves the timing to the controller
`timescale 1ns/1ps
module mct_mem_model (
  input wire logic core_clk, cs_out, ack_size,
  input wire logic [3:0] ack_after,
  output logic size_ack_input, transfer_ack_input
);
  logic [3:0] cnt_reg;
  logic ack;
  assign ack = cs_out && ack_after != 4'h0 && cnt_reg == ack_after;
  assign size_ack_input = ack && ack_size;
  assign transfer_ack_input = ack && !ack_size;
  always @(posedge core_clk)
    cnt_reg <= cs_out ? cnt_reg + 4'h1 : 4'h0;
endmodule : mct_mem_model

// *** verification/test_memory_controller_timing.sv ***
// Purpose: Self-checking bench for mct_top
// Assumes: 20 MHz clock, sync reset, APB master
// Notes: Cycle lengths are checked as differences
`timescale 1ns/1ps
`include "mct_regs.svh"
module test_memory_controller_timing;
  logic core_clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
  logic acc_req, acc_write, acc_burst, port32, acc_done, cas_out, cs_out;
  logic burst_inhibit_output, page_hit, parity_active, refresh_req, hit;
  logic size_ack_input, transfer_ack_input, ack_size, p;
  logic [1:0] cfg_pin;
  logic [3:0] ack_after;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [25:0] acc_addr, a;
  int failures, samples_checked, cyc, n, nr, base, w, b, k;
  mct_top uut (.core_clk, .sys_rst, .cfg_pin, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .acc_req, .acc_write,
    .acc_burst, .port32, .acc_addr, .size_ack_input, .transfer_ack_input,
    .acc_done, .cas_out, .cs_out, .burst_inhibit_output, .page_hit,
    .parity_active, .refresh_req);
  mct_mem_model mem_i (.core_clk, .cs_out, .ack_size, .ack_after,
    .size_ack_input, .transfer_ack_input);
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic chk(input string s, input logic [31:0] e, g);
    samples_checked++;
    if (e !== g) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] ad,
      input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  task automatic mem(input logic wr, input logic [25:0] ad);
    acc_req <= 1'b1;
    acc_write <= wr;
    acc_addr <= ad;
    n = 0;
    k = 0;
    @(posedge core_clk);
    acc_req <= 1'b0;
    do begin
      @(posedge core_clk);
      n++;
      if (cs_out === 1'b1) k++;
    end while (acc_done !== 1'b1);
    hit = page_hit;
    repeat (2) @(posedge core_clk);
  endtask : mem
  task automatic gap();
    n = 0;
    do @(posedge core_clk); while (refresh_req !== 1'b1);
    do begin
      @(posedge core_clk);
      n++;
    end while (refresh_req !== 1'b1);
  endtask : gap
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    void'($urandom(5186));
    {psel, penable, pwrite, acc_req, acc_write, acc_burst, port32} = '0;
    {paddr, pwdata, acc_addr, ack_after, ack_size} = '0;
    cfg_pin = 2'($urandom);
    sys_rst = 1'b1;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    apb(0, `MCT_OPT_OFF, 0);
    chk("opt_rst", {cfg_pin, 2'b00}, q[7:0]);
    apb(0, `MCT_GMR_OFF, 0);
    chk("refresh_period_count_rst", `MCT_REFRESH_PERIOD_COUNT_RST, q[7:0]);
    apb(0, 12'h010, 0);
    chk("unmapped", 1, err);
    w = $urandom_range(7);
    apb(1, `MCT_GMR_OFF, w);
    repeat (2) begin
      gap();
      chk("refresh_gap", 16 * (w + 1), n);
    end
    $display("end reset and refresh");
    apb(1, `MCT_OPT_OFF, 32'h0000_0001);
    acc_burst <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      w = i == 0 ? 0 : i == 1 ? 15 : $urandom_range(14);
      apb(1, `MCT_CYC_OFF, w);
      mem(0, 0);
      if (i == 0) base = n;
      chk("burst_len", base + w, n);
    end
    apb(1, `MCT_OPT_OFF, 32'h0000_0081);
    mem(0, 0);
    chk("setup_len", base + w + 1, n);
    for (int i = 0; i < 2; i++) begin
      apb(1, `MCT_OPT_OFF, 32'h0000_0041 | (i << 5));
      mem(0, 0);
      chk("early_neg", base + w - 2, k);
    end
    acc_burst <= 1'b0;
    $display("end burst length");
    apb(1, `MCT_CYC_OFF, 0);
    apb(1, `MCT_OPT_OFF, 32'h0000_000D);
    for (int i = 0; i < 2; i++) begin
      a = 26'($urandom);
      mem(0, a);
      mem(0, a);
      nr = n;
      chk("read_hit", 1, hit);
      mem(1, a);
      chk("write_len", nr + 1 - i, n);
      apb(1, `MCT_CYC_OFF, 1);
      apb(1, `MCT_OPT_OFF, 32'h0000_0009);
    end
    for (w = 0; w < 8; w++) begin
      apb(1, `MCT_GMR_OFF, {21'h0, w[2:0], 8'hFF});
      p = 1'($urandom);
      port32 <= p;
      b = 10 + (w + 1) / 2 - int'(!p);
      a = 26'($urandom);
      mem(0, a);
      mem(0, a ^ (26'h1 << (b - 1)));
      chk("same_page", 1, hit);
      mem(0, a ^ (26'h1 << b));
      chk("new_page", 0, hit);
    end
    $display("end page and write delay");
    apb(1, `MCT_CYC_OFF, 15);
    ack_after <= 4'h2;
    for (int i = 0; i < 2; i++) begin
      ack_size <= i[0];
      apb(1, `MCT_OPT_OFF, 32'h0000_0003 | (i << 4));
      mem(0, 0);
      chk("ack_end", 1, n < base + 15);
    end
    $display("end acknowledge");
    give_verdict();
  end
endmodule : test_memory_controller_timing
bind mct_top mct_top_chk chk_i (.core_clk, .sys_rst, .psel, .penable,
  .pwrite, .pready, .paddr, .pwdata, .prdata, .pslverr, .acc_done, .cs_out,
  .burst_inhibit_output, .parity_active, .refresh_req, .size_ack_input,
  .transfer_ack_input);
